// ### core/serial_port_pkg.sv
// Constants, register map and types shared by the serial command port
package serial_port_pkg;

	// Bus geometry
	localparam int            ADDR_W      = 4;
	localparam int            DATA_W      = 32;
	// Register byte offsets
	localparam logic [3:0]    REG_CTRL    = 4'h0;
	localparam logic [3:0]    REG_STATUS  = 4'h4;
	localparam logic [3:0]    REG_RXDATA  = 4'h8;
	localparam logic [3:0]    REG_TXDATA  = 4'hC;
	// Control register field positions
	localparam int            CTRL_BAUD_LO = 0;
	localparam int            CTRL_FLOW    = 3;
	localparam int            CTRL_TERM_LO = 4;
	localparam int            CTRL_CMDSET  = 6;
	localparam int            CTRL_SERIAL  = 7;
	// Status register field positions
	localparam int            ST_CMD_READY = 0;
	localparam int            ST_RX_EMPTY  = 1;
	localparam int            ST_TX_FULL   = 2;
	localparam int            ST_HOLD_OFF  = 3;
	localparam int            ST_XOFF_SENT = 4;
	localparam int            ST_OVERRUN   = 5;
	localparam int            ST_FRAME_ERR = 6;
	localparam int            ST_COUNT_LO  = 8;
	// Data register fields
	localparam int            RX_VALID_BIT = 8;
	localparam int            TX_EOM_BIT   = 8;
	// Bit rate selection codes
	localparam logic [2:0]    BAUD_19200  = 3'h0;
	localparam logic [2:0]    BAUD_9600   = 3'h1;
	localparam logic [2:0]    BAUD_4800   = 3'h2;
	localparam logic [2:0]    BAUD_2400   = 3'h3;
	localparam logic [2:0]    BAUD_1200   = 3'h4;
	localparam logic [2:0]    BAUD_600    = 3'h5;
	localparam logic [2:0]    BAUD_300    = 3'h6;
	// Line ending selection codes
	localparam logic [1:0]    TERM_LF     = 2'h0;
	localparam logic [1:0]    TERM_CR     = 2'h1;
	localparam logic [1:0]    TERM_CRLF   = 2'h2;
	localparam logic [1:0]    TERM_LFCR   = 2'h3;
	// Command set codes
	localparam logic          CMDSET_STD  = 1'b0;
	localparam logic          CMDSET_LEG  = 1'b1;
	// Reset values
	localparam logic [2:0]    RST_BAUD    = BAUD_9600;
	localparam logic [1:0]    RST_TERM    = TERM_LF;
	localparam logic          RST_FLOW    = 1'b0;
	localparam logic          RST_SERIAL  = 1'b0;
	// Special characters
	localparam logic [7:0]    CHR_CTRL_C  = 8'h03;
	localparam logic [7:0]    CHR_CTRL_X  = 8'h18;
	localparam logic [7:0]    CHR_XON     = 8'h11;
	localparam logic [7:0]    CHR_XOFF    = 8'h13;
	localparam logic [7:0]    CHR_CR      = 8'h0D;
	localparam logic [7:0]    CHR_LF      = 8'h0A;
	// Framing
	localparam int            DATA_BITS   = 8;
	localparam int            DIV_W       = 20;

	// Serial state machines share one encoding
	typedef enum logic [1:0]
	{
		LN_IDLE  = 2'b00,
		LN_START = 2'b01,
		LN_DATA  = 2'b10,
		LN_STOP  = 2'b11
	} line_state_t;

	// Clock cycles per bit for a rate code; unknown codes fall back to 9600
	function automatic logic [DIV_W-1:0] bitCycles(input int clkHz, input logic [2:0] sel);
		int rate;
		rate = 9600;
		case (sel)
			BAUD_19200: rate = 19200;
			BAUD_4800:  rate = 4800;
			BAUD_2400:  rate = 2400;
			BAUD_1200:  rate = 1200;
			BAUD_600:   rate = 600;
			BAUD_300:   rate = 300;
			default:    rate = 9600;
		endcase
		return DIV_W'(clkHz / rate);
	endfunction

endpackage

// ### core/serial_command_port.sv
// Serial command port with software flow control and its queue FIFO
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

// Synchronous FIFO; depth must be a power of two so pointers wrap freely
module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire logic                         flush,
	input  wire logic                         inValid,
	output logic                              inReady,
	input  wire logic [WIDTH-1:0]             inData,
	output logic                              outValid,
	input  wire logic                         outReady,
	output logic [WIDTH-1:0]                  outData,
	output logic [$clog2(DEPTH+1)-1:0]        count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	// All FIFO state in one record
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage words
		logic [AW-1:0]               rdPtr;  // Next word to read
		logic [AW-1:0]               wrPtr;  // Next word to write
		logic [CW-1:0]               fill;   // Words held
	} fifo_t;

	fifo_t st;
	fifo_t next_st;
	logic  push;
	logic  pop;

	// Honest flags straight from the fill count
	assign inReady  = (st.fill != CW'(DEPTH));
	assign outValid = (st.fill != '0);
	assign outData  = st.mem[st.rdPtr];
	assign count    = st.fill;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Pointer and fill update; flush wins over any transfer
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = st.wrPtr + AW'(1);
		end
		if (pop)
			next_st.rdPtr = st.rdPtr + AW'(1);
		next_st.fill = st.fill + CW'(push) - CW'(pop);
		if (flush)
		begin
			// Words stay in memory but become unreachable
			next_st.rdPtr = '0;
			next_st.wrPtr = '0;
			next_st.fill  = '0;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			st <= '0;
		else if (ce)
			st <= next_st;
	end
endmodule

// Top: Wishbone slave, 8N1 transmitter and receiver, flow control
module serial_command_port
	import serial_port_pkg::*;
#(
	parameter int CLK_HZ = 100_000_000,
	parameter int DEPTH  = 8
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	input  wire logic                          ifcReset,
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [serial_port_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [serial_port_pkg::DATA_W-1:0] dat_i,
	input  wire logic [3:0]                    sel_i,
	output logic [serial_port_pkg::DATA_W-1:0] dat_o,
	output logic                               ack_o,
	input  wire logic                          serialRx,
	output logic                               serialTx,
	output logic                               abortOp,
	output logic                               bufferClear
);
	import serial_port_pkg::*;

	localparam int CW      = $clog2(DEPTH+1);
	localparam int FILL_HI = (DEPTH * 3) / 4;   // XOFF above this
	localparam int FILL_LO = DEPTH / 2;         // XON below this

	// Whole block state in one record
	typedef struct packed {
		logic [2:0]       baudSel;     // Rate code
		logic             flowEn;      // software_flow_select
		logic [1:0]       termSel;     // Line ending code
		logic             cmdSet;      // command_set_select
		logic             serialOn;    // Serial interface is the active one
		line_state_t      txState;     // Transmit sequencer
		logic [DIV_W-1:0] txCnt;       // Cycles left in current bit
		logic [2:0]       txBit;       // Data bit index
		logic [7:0]       txShift;     // Outgoing character
		logic             txd;         // Line level
		logic [1:0]       termStep;    // Line ending characters still owed
		line_state_t      rxState;     // Receive sequencer
		logic [DIV_W-1:0] rxCnt;       // Cycles to next sample
		logic [2:0]       rxBit;       // Data bit index
		logic [7:0]       rxShift;     // Incoming character
		logic             holdOff;     // Host asked us to pause
		logic             xoffSent;    // We asked the host to pause
		logic [CW-1:0]    crCount;     // Complete commands queued
		logic             overrun;     // Sticky: character lost
		logic             frameErr;    // Sticky: bad stop bit
		logic             abortOp;     // One-cycle abort pulse
		logic             bufClr;      // One-cycle interface-switch pulse
		logic             ack;         // Bus acknowledge
		logic [DATA_W-1:0] rdat;       // Registered read data
	} port_t;

	port_t            st;
	port_t            next_st;
	logic [DIV_W-1:0] bitLen;          // Cycles per bit at current rate
	logic             busReq;          // New bus cycle awaiting answer
	logic             rxPush;
	logic [7:0]       rxByte;
	logic             rxInReady;
	logic             rxOutValid;
	logic             rxPop;
	logic [7:0]       rxHead;
	logic [CW-1:0]    rxFill;
	logic             txPush;
	logic             txInReady;
	logic             txOutValid;
	logic             txPop;
	logic [8:0]       txHead;
	logic [CW-1:0]    txFill;
	logic             flushAll;
	logic             ovEvent;         // Overrun raised this cycle
	logic             feEvent;         // Frame error raised this cycle

	assign bitLen      = bitCycles(CLK_HZ, st.baudSel);
	assign busReq      = cyc_i && stb_i && !st.ack;
	assign dat_o       = st.rdat;
	assign ack_o       = st.ack;
	assign serialTx    = st.txd;
	assign abortOp     = st.abortOp;
	assign bufferClear = st.bufClr;

	// Input queue: command characters; break codes never, XON/XOFF only with flow control off
	cmd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxQueue (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.flush    (flushAll),
		.inValid  (rxPush),
		.inReady  (rxInReady),
		.inData   (rxByte),
		.outValid (rxOutValid),
		.outReady (rxPop),
		.outData  (rxHead),
		.count    (rxFill)
	);

	// Output queue: bit 8 marks the last character of a message
	cmd_fifo #(.WIDTH(9), .DEPTH(DEPTH)) txQueue (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.flush    (flushAll),
		.inValid  (txPush),
		.inReady  (txInReady),
		.inData   (dat_i[TX_EOM_BIT:0]),
		.outValid (txOutValid),
		.outReady (txPop),
		.outData  (txHead),
		.count    (txFill)
	);

	// Main next-state logic
	always_comb
	begin
		next_st     = st;
		rxPush      = 1'b0;
		rxByte      = st.rxShift;
		rxPop       = 1'b0;
		txPush      = 1'b0;
		txPop       = 1'b0;
		flushAll    = ifcReset;
		ovEvent     = 1'b0;
		feEvent     = 1'b0;
		next_st.abortOp = 1'b0;
		next_st.bufClr  = 1'b0;
		next_st.ack     = 1'b0;

		// Receiver: half-bit wait, then sample mid-bit
		unique case (st.rxState)
			LN_IDLE:
				if (!serialRx)
				begin
					next_st.rxState = LN_START;
					next_st.rxCnt   = bitLen >> 1;
				end
			LN_START:
				if (st.rxCnt == '0)
				begin
					// A glitch shorter than half a bit is ignored
					next_st.rxState = serialRx ? LN_IDLE : LN_DATA;
					next_st.rxCnt   = bitLen - DIV_W'(1);
					next_st.rxBit   = '0;
				end
				else
					next_st.rxCnt = st.rxCnt - DIV_W'(1);
			LN_DATA:
				if (st.rxCnt == '0)
				begin
					next_st.rxShift = {serialRx, st.rxShift[7:1]};
					next_st.rxCnt   = bitLen - DIV_W'(1);
					next_st.rxBit   = st.rxBit + 3'h1;
					if (st.rxBit == 3'(DATA_BITS - 1))
						next_st.rxState = LN_STOP;
				end
				else
					next_st.rxCnt = st.rxCnt - DIV_W'(1);
			LN_STOP:
				if (st.rxCnt == '0)
				begin
					next_st.rxState = LN_IDLE;
					if (!serialRx)
						{next_st.frameErr, feEvent} = 2'b11;
					else if (!st.serialOn)
						next_st.rxState = LN_IDLE;      // Port idle: drop it
					else if (st.rxShift == CHR_CTRL_C || st.rxShift == CHR_CTRL_X)
					begin
						// Break: abort and discard queued input and output
						next_st.abortOp = 1'b1;
						flushAll        = 1'b1;
					end
					else if (st.flowEn && st.rxShift == CHR_XOFF)
						next_st.holdOff = 1'b1;
					else if (st.flowEn && st.rxShift == CHR_XON)
						next_st.holdOff = 1'b0;
					else if (st.cmdSet != CMDSET_STD)
						next_st.rxState = LN_IDLE;      // Legacy set not served here
					else if (rxInReady)
						rxPush = 1'b1;
					else
						{next_st.overrun, ovEvent} = 2'b11; // No room: character lost
				end
				else
					next_st.rxCnt = st.rxCnt - DIV_W'(1);
		endcase

		// Transmitter: flow characters first, then line ending, then data
		unique case (st.txState)
			LN_IDLE:
			begin
				next_st.txd = 1'b1;
				if (st.flowEn && !st.xoffSent && rxFill > CW'(FILL_HI))
				begin
					next_st.txShift  = CHR_XOFF;
					next_st.xoffSent = 1'b1;
					next_st.txState  = LN_START;
				end
				else if (st.flowEn && st.xoffSent && rxFill < CW'(FILL_LO))
				begin
					next_st.txShift  = CHR_XON;
					next_st.xoffSent = 1'b0;
					next_st.txState  = LN_START;
				end
				else if (!st.holdOff && st.termStep != 2'h0)
				begin
					// Append the chosen line ending
					next_st.txState = LN_START;
					if (st.termStep == 2'h2)
					begin
						next_st.txShift  = (st.termSel == TERM_CRLF) ? CHR_LF : CHR_CR;
						next_st.termStep = 2'h0;
					end
					else
					begin
						next_st.txShift  = (st.termSel == TERM_LF ||
							st.termSel == TERM_LFCR) ? CHR_LF : CHR_CR;
						next_st.termStep = (st.termSel == TERM_CRLF ||
							st.termSel == TERM_LFCR) ? 2'h2 : 2'h0;
					end
				end
				else if (!st.holdOff && txOutValid)
				begin
					// Host pause halts data here, never mid-character
					txPop            = 1'b1;
					next_st.txShift  = txHead[7:0];
					next_st.termStep = txHead[TX_EOM_BIT] ? 2'h1 : 2'h0;
					next_st.txState  = LN_START;
				end
				// Full count: the line only drops one edge later, so the start bit is whole
				next_st.txCnt = bitLen;
				next_st.txBit = '0;
			end
			LN_START:
			begin
				next_st.txd = 1'b0;
				if (st.txCnt == '0)
				begin
					next_st.txState = LN_DATA;
					next_st.txCnt   = bitLen - DIV_W'(1);
					next_st.txd     = st.txShift[0];
				end
				else
					next_st.txCnt = st.txCnt - DIV_W'(1);
			end
			LN_DATA:
				if (st.txCnt == '0)
				begin
					next_st.txCnt = bitLen - DIV_W'(1);
					if (st.txBit == 3'(DATA_BITS - 1))
					begin
						next_st.txState = LN_STOP;
						next_st.txd     = 1'b1;
					end
					else
					begin
						next_st.txBit   = st.txBit + 3'h1;
						next_st.txShift = {1'b0, st.txShift[7:1]};
						next_st.txd     = st.txShift[1];
					end
				end
				else
					next_st.txCnt = st.txCnt - DIV_W'(1);
			LN_STOP:
				// One stop bit, no parity slot
				if (st.txCnt == '0)
					next_st.txState = LN_IDLE;
				else
					next_st.txCnt = st.txCnt - DIV_W'(1);
		endcase

		// Without software flow no flow characters are owed
		if (!st.flowEn)
		begin
			next_st.xoffSent = 1'b0;
			next_st.holdOff  = 1'b0;
		end

		// Wishbone classic slave, answer one cycle after the request; transmit writes to a full queue wait for room
		if (busReq)
		begin
			next_st.ack  = 1'b1;
			next_st.rdat = '0;
			unique case (adr_i)
				REG_CTRL:
					if (we_i && sel_i[0])
					begin
						next_st.baudSel  = dat_i[CTRL_BAUD_LO +: 3];
						next_st.flowEn   = dat_i[CTRL_FLOW];
						next_st.termSel  = dat_i[CTRL_TERM_LO +: 2];
						next_st.cmdSet   = dat_i[CTRL_CMDSET];
						next_st.serialOn = dat_i[CTRL_SERIAL];
						if (dat_i[CTRL_SERIAL] != st.serialOn)
						begin
							// Interface switch empties buffers
							next_st.bufClr = 1'b1;
							flushAll       = 1'b1;
						end
					end
					else
					begin
						next_st.rdat[CTRL_BAUD_LO +: 3] = st.baudSel;
						next_st.rdat[CTRL_FLOW]         = st.flowEn;
						next_st.rdat[CTRL_TERM_LO +: 2] = st.termSel;
						next_st.rdat[CTRL_CMDSET]       = st.cmdSet;
						next_st.rdat[CTRL_SERIAL]       = st.serialOn;
					end
				REG_STATUS:
					if (we_i && sel_i[0])
					begin
						// Write one clears; a new event this cycle wins
						if (dat_i[ST_OVERRUN] && !ovEvent)
							next_st.overrun = 1'b0;
						if (dat_i[ST_FRAME_ERR] && !feEvent)
							next_st.frameErr = 1'b0;
					end
					else
					begin
						next_st.rdat[ST_CMD_READY] = (st.crCount != '0);
						next_st.rdat[ST_RX_EMPTY]  = !rxOutValid;
						next_st.rdat[ST_TX_FULL]   = !txInReady;
						next_st.rdat[ST_HOLD_OFF]  = st.holdOff;
						next_st.rdat[ST_XOFF_SENT] = st.xoffSent;
						next_st.rdat[ST_OVERRUN]   = st.overrun;
						next_st.rdat[ST_FRAME_ERR] = st.frameErr;
						next_st.rdat[ST_COUNT_LO +: CW] = rxFill;
					end
				REG_RXDATA:
					// Characters leave only once a whole command is
					if (!we_i && st.crCount != '0 && rxOutValid)
					begin
						rxPop = 1'b1;
						next_st.rdat[7:0]          = rxHead;
						next_st.rdat[RX_VALID_BIT] = 1'b1;
					end
				REG_TXDATA:
					if (we_i && sel_i[0] && sel_i[1])
					begin
						// A full queue stalls the bus until room appears
						txPush      = txInReady;
						next_st.ack = txInReady;
					end
				default:
					next_st.rdat = '0;              // Unmapped: ack, read zero
			endcase
		end

		// Count complete commands held in the input queue
		next_st.crCount = st.crCount + CW'(rxPush && rxByte == CHR_CR)
			- CW'(rxPop && rxHead == CHR_CR);
		if (flushAll)
		begin
			next_st.crCount  = '0;
			next_st.termStep = 2'h0;          // Discard owed line ending
		end
	end

	// State register; command set is not touched by the interface reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			st          <= '0;
			st.baudSel  <= RST_BAUD;
			st.flowEn   <= RST_FLOW;
			st.termSel  <= RST_TERM;
			st.cmdSet   <= CMDSET_STD;
			st.serialOn <= RST_SERIAL;
			st.txState  <= LN_IDLE;
			st.rxState  <= LN_IDLE;
			st.txd      <= 1'b1;
		end
		else if (ce)
			st <= next_st;
	end
	// No handshake lines exist on this port by design
endmodule

// ### verification/serial_command_port_monitor.sv
// Checker for the serial command port bus and line timing
`timescale 1ns/1ps
module serial_port_monitor
	import serial_port_pkg::*;
(
	input wire logic                                ref_clk,
	input wire logic                                rst_n,
	input wire logic                                ce,
	input wire logic                                cyc_i,
	input wire logic                                stb_i,
	input wire logic                                we_i,
	input wire logic [serial_port_pkg::ADDR_W-1:0] adr_i,
	input wire logic [serial_port_pkg::DATA_W-1:0] dat_i,
	input wire logic [3:0]                          sel_i,
	input wire logic [serial_port_pkg::DATA_W-1:0] dat_o,
	input wire logic                                ack_o,
	input wire logic                                serialTx,
	input wire logic                                abortOp,
	input wire logic                                bufferClear
);
	logic onBit; // Mirror of the port-enable bit
	logic take;  // A request is taken at this edge
	logic wrCtl; // Taken write to the control byte
	assign take = ce && cyc_i && stb_i && !ack_o;
	assign wrCtl = take && we_i && adr_i == REG_CTRL && sel_i[0];
	// Follow the port-enable bit so a switch can be recognised
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			onBit <= 1'b0;
		else if (wrCtl)
			onBit <= dat_i[7];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	ack_pulse_a:
	assert property (ack_o |=> !ack_o) else $error("ack held too long");
	// Transmit writes may wait for room, so they are left out here
	ack_time_a:
	assert property (take && !(we_i && adr_i == REG_TXDATA) |=> ack_o)
		else $error("no ack one cycle after request");
	dat_hold_a:
	assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
	tx_idle_a:
	assert property ($rose(rst_n) |-> serialTx) else $error("line not idle");
	start_bit_a:
	assert property ($fell(serialTx) |-> !serialTx [*8]) else $error("start bit short");
	abort_pulse_a:
	assert property (abortOp |=> !abortOp) else $error("abort pulse too long");
	clr_switch_a:
	assert property (wrCtl && dat_i[7] != onBit |-> ##[1:2] bufferClear)
		else $error("no buffer clear on switch");
	clr_pulse_a:
	assert property (bufferClear |=> !bufferClear) else $error("clear pulse too long");
	quiet_reset_a:
	assert property ($rose(rst_n) |-> !ack_o && !abortOp && !bufferClear)
		else $error("outputs busy after reset");
	cover property (abortOp);
	cover property (bufferClear);
	cover property (ack_o && we_i && adr_i == REG_TXDATA);
endmodule
bind serial_command_port serial_port_monitor mon_u (.ref_clk, .rst_n, .ce, .cyc_i, .stb_i,
	.we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .serialTx, .abortOp, .bufferClear);

// ### verification/host_uart_model.sv
// Host controller model: 8N1 sender and receiver honouring XON/XOFF
`timescale 1ns/1ps
module host_uart_model
	import serial_port_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        lineIn,
	input wire logic [15:0] bitCyc,
	output logic            lineOut
);
	logic [7:0] got[$]; // Bytes heard from the port
	logic       paused; // Port asked us to stop
	initial
	begin
		lineOut = 1'b1;
		paused = 1'b0;
	end
	// Sample mid-cell, LSB first, same rate as the port
	always
	begin : rxProc
		logic [7:0] b;
		@(negedge lineIn);
		repeat (bitCyc + bitCyc / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = lineIn;
			repeat (bitCyc) @(posedge ref_clk);
		end
		// Stop sending after XOFF until XON
		if (b == CHR_XOFF)
			paused = 1'b1;
		else if (b == CHR_XON)
			paused = 1'b0;
		got.push_back(b);
	end
	// One frame: start, eight bits, one stop, no parity
	task automatic sendByte(input logic [7:0] b);
		int k;
		k = 0;
		while (paused && k < 50000)
		begin
			@(posedge ref_clk);
			k++;
		end
		for (int i = 0; i < 10; i++)
		begin
			lineOut <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
			repeat (bitCyc) @(posedge ref_clk);
		end
	endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
module tb;
	import serial_port_pkg::*;
	localparam int CLK = 250_000; // Slow model clock keeps bit times short
	logic        ref_clk, rst_n, ce, ifcReset, cyc_i, stb_i, we_i;
	logic [3:0]  adr_i, sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic        ack_o, serialRx, serialTx, abortOp, bufferClear;
	logic [15:0] bitCyc; // Bit time shared with the host
	logic [1:0]  term;   // Line ending selected now
	logic [7:0]  c;
	logic [7:0]  expTx[$]; // Bytes the host must hear
	logic [7:0]  expRx[$]; // Bytes software must read
	int          numErrors = 0;
	int          totalChecks = 0;
	int          seed = 61;
	int          nAbort = 0;
	int          nClear = 0;
	int          rates[7] = '{19200, 9600, 4800, 2400, 1200, 600, 300};

	serial_command_port #(.CLK_HZ(CLK), .DEPTH(8)) dut_u (.ref_clk, .rst_n, .ce, .ifcReset,
		.cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .serialRx, .serialTx,
		.abortOp, .bufferClear);
	host_uart_model host_u (.ref_clk, .lineIn(serialTx), .bitCyc, .lineOut(serialRx));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Count pulses; a pulse must be one cycle so counts are exact
	always @(posedge ref_clk)
	begin
		nAbort += (abortOp === 1'b1);
		nClear += (bufferClear === 1'b1);
	end

	task automatic wrapUp();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// A wait that used its bound ends the run
	task automatic guard(input int k, input int lim);
		if (k >= lim)
		begin
			numErrors++;
			wrapUp();
		end
	endtask
	// Classic single cycle; held until ack, read data left in q
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge ref_clk);
		while (ack_o !== 1'b1 && k < 20000)
		begin
			@(posedge ref_clk);
			k++;
		end
		guard(k, 20000);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdChk(input string n, input logic [3:0] a, input logic [31:0] m, e);
		wb(1'b0, a, 32'h0);
		chk(n, q & m, e);
	endtask
	task automatic setCtrl(input logic [7:0] v);
		wb(1'b1, REG_CTRL, {24'h0, v});
		term = v[5:4];
		bitCyc = 16'(CLK / rates[v[2:0]]);
	endtask
	// Queue a character; end of message owes the line ending
	task automatic wrTx(input logic [7:0] b, input logic eom);
		wb(1'b1, REG_TXDATA, {23'h0, eom, b});
		expTx.push_back(b);
		if (eom)
			case (term)
				TERM_LF: expTx.push_back(CHR_LF);
				TERM_CR: expTx.push_back(CHR_CR);
				TERM_CRLF: expTx = {expTx, CHR_CR, CHR_LF};
				default: expTx = {expTx, CHR_LF, CHR_CR};
			endcase
	endtask
	task automatic hostSend(input logic [7:0] b, input logic keep);
		// A host still paused here would only leave its bounded wait by timeout
		chk("host free", host_u.paused, 1'b0);
		host_u.sendByte(b);
		if (keep)
			expRx.push_back(b);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic popRx(input int n);
		repeat (n) rdChk("rx data", REG_RXDATA, 32'h1FF, {23'h1, expRx.pop_front()});
	endtask
	task automatic drainHost(input string n);
		int k;
		k = 0;
		while (host_u.got.size() < expTx.size() && k < 40000)
		begin
			@(posedge ref_clk);
			k++;
		end
		guard(k, 40000);
		chk(n, host_u.got.size(), expTx.size());
		foreach (expTx[i])
			chk(n, host_u.got[i], expTx[i]);
		expTx.delete();
		host_u.got.delete();
	endtask

	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		ifcReset = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 4'h0;
		dat_i = 32'h0;
		sel_i = 4'hF;
		term = TERM_LF;
		bitCyc = 16'(CLK / 9600);
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rdChk("ctrl reset", REG_CTRL, 32'hFF, 32'h01);
		rdChk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
		// Every rate code and line ending with random text
		for (int k = 0; k < 7; k++)
		begin
			setCtrl({2'b10, (k < 4) ? 2'(k) : TERM_LF, 1'b0, 3'(k)});
			c = 8'h20 + 8'($random(seed) & 32'h3F);
			wrTx(c, 1'b1);
			drainHost("tx frame");
		end
		$display("rates and endings done");
		setCtrl(8'h80);
		hostSend(8'h41, 1'b1);
		hostSend(8'h42, 1'b1);
		rdChk("rx before cr", REG_RXDATA, 32'h1FF, 32'h0);
		hostSend(CHR_CR, 1'b1);
		popRx(3);
		// Both abort codes; the pending character is lost
		hostSend(8'h51, 1'b0);
		hostSend(CHR_CTRL_C, 1'b0);
		hostSend(CHR_CTRL_X, 1'b0);
		chk("abort pulses", nAbort, 2);
		hostSend(CHR_CR, 1'b1);
		popRx(1);
		$display("receive and abort done");
		setCtrl(8'h88);
		for (int i = 0; i < 6; i++)
			hostSend(8'h61 + 8'(i), 1'b1);
		hostSend(CHR_CR, 1'b1);
		expTx.push_back(CHR_XOFF);
		drainHost("xoff");
		popRx(4);
		expTx.push_back(CHR_XON);
		drainHost("xon");
		popRx(3);
		// Host XOFF holds output while the transmit queue fills
		hostSend(CHR_XOFF, 1'b0);
		rdChk("held not queued", REG_STATUS, 32'hF08, 32'h08);
		for (int i = 0; i < 8; i++)
			wrTx(8'h30 + 8'(i), i == 7);
		rdChk("tx full", REG_STATUS, 32'h4, 32'h4);
		repeat (20 * bitCyc) @(posedge ref_clk);
		chk("held output", host_u.got.size(), 0);
		hostSend(CHR_XON, 1'b0);
		drainHost("resume");
		// Flow off: no flow characters, the ninth character is lost and flagged
		setCtrl(8'h80);
		for (int i = 0; i < 9; i++)
			hostSend(8'h70 + 8'(i), 1'b0);
		rdChk("overrun", REG_STATUS, 32'hF20, 32'h820);
		wb(1'b1, REG_STATUS, 32'h20);
		rdChk("overrun clear", REG_STATUS, 32'h20, 32'h0);
		// Transmit write without both byte selects must be ignored
		sel_i <= 4'h1;
		wb(1'b1, REG_TXDATA, 32'h141);
		sel_i <= 4'hF;
		hostSend(CHR_CTRL_C, 1'b0);
		chk("nothing sent", host_u.got.size(), 0);
		$display("flow control done");
		setCtrl(8'hC8);
		hostSend(8'h5A, 1'b0);
		hostSend(CHR_CR, 1'b0);
		rdChk("legacy drop", REG_STATUS, 32'h3, 32'h2);
		ifcReset <= 1'b1;
		@(posedge ref_clk);
		ifcReset <= 1'b0;
		rdChk("set kept", REG_CTRL, 32'hFF, 32'hC8);
		setCtrl(8'h08);
		repeat (3) @(posedge ref_clk);
		chk("switch clears", nClear, 2);
		$display("command set done");
		wrapUp();
	end
endmodule
